//--- common/tcap_pkg.sv
// Purpose: constants for the three-channel capture timer
// Assumes: byte-wide register port, 16-bit read data
// Notes:   offsets are the addresses of the register port
package tcap_pkg;
    // ==========================================================
    // Register addresses
    localparam logic [15:0] ADDR_MODE     = 16'hFF65;
    localparam logic [15:0] ADDR_PRESCALE = 16'hFF66;
    localparam logic [15:0] ADDR_DIVIDER  = 16'hFF67;
    localparam logic [15:0] ADDR_COUNT    = 16'hFF60;
    localparam logic [15:0] ADDR_CAP0     = 16'hFF62;
    localparam logic [15:0] ADDR_CAP1     = 16'hFF68;
    localparam logic [15:0] ADDR_CAP2     = 16'hFF6A;
    // ==========================================================
    // Field positions
    localparam int MODE_OUT_EN_BIT = 0;
    localparam int MODE_RUN_BIT    = 2;
    localparam int PRS_SEL_LSB     = 0;
    localparam int EDGE0_LSB       = 2;
    localparam int EDGE1_LSB       = 4;
    localparam int EDGE2_LSB       = 6;
    localparam int DIV_SEL_LSB     = 0;
    // ==========================================================
    // Reset values
    localparam logic [7:0]  MODE_RST     = 8'h00;
    localparam logic [7:0]  PRESCALE_RST = 8'h00;
    localparam logic [7:0]  DIVIDER_RST  = 8'h00;
    localparam logic [15:0] COUNT_RST    = 16'h0000;
    // ==========================================================
    // Edge codes; 2'h2 is prohibited and detects nothing
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // Prescaler: count clock is REF_CLK / 2^(PRS_BASE_LOG2 + sel)
    localparam int PRS_BASE_LOG2 = 3;
    localparam int PRS_WIDTH     = 6;
endpackage

//--- rtl/tcap_timer.sv
// Purpose: 16-bit free-running timer with three capture channels
// Assumes: one REF_CLK domain; byte register port with strobes
// Notes:   count clock is a one-cycle tick, not a derived clock
`timescale 1ns/1ps

// What this block does
// R01: read-only 16-bit counter, reset to zero
// R02: counter undefined while stopped; here it holds
// R03: channel zero edge captures and interrupts
// R04: channel one edge captures and interrupts
// R05: channel two edge after division captures
// R06: capture registers 16 bits, no reset
// R07: mode bit 2 runs the timer
// R08: mode bit 0 enables prescaler output
// R09: software writes zero to mode spares
// R10: software stops timer before mode change
// R11: divider field divides channel two by 1..8
// R12: software stops timer before divider write
// R13: per-channel edge select, falling/rising/both
// R14: prescaler select: divide by 8..64
// R15: software stops timer before prescaler write
// R16: mode resets zero; bit and byte writes
// R17: capture copies current counter value
// R18: inputs sampled at count clock, twice
// R19: counter wraps freely, no compare clear
module tcap_timer (
    input  wire logic        REF_CLK,
    input  wire logic        SRST,
    input  wire logic [15:0] ADDR,
    input  wire logic        WR_BYTE,
    input  wire logic        WR_BIT,
    input  wire logic [2:0]  BIT_SEL,
    input  wire logic        BIT_VAL,
    input  wire logic [7:0]  WDATA,
    input  wire logic        RD,
    input  wire logic        CAPTURE_INPUT_ZERO,
    input  wire logic        CAPTURE_INPUT_ONE,
    input  wire logic        CAPTURE_INPUT_TWO,
    output logic [15:0]      RDATA,
    output logic             CAPTURE_IRQ_ZERO,
    output logic             CAPTURE_IRQ_ONE,
    output logic             CAPTURE_IRQ_TWO,
    output logic             PRESCALER_OUT
);
    // ==========================================================
    // State
    typedef struct packed {
        logic [7:0]  mode;
        logic [7:0]  prs;
        logic [7:0]  div;
        logic [15:0] count;
        logic [15:0] cap0;
        logic [15:0] cap1;
        logic [15:0] cap2;
        logic [5:0]  pre;
        logic [2:0]  sync1;
        logic [2:0]  sync2;
        logic [2:0]  samp_a;
        logic [2:0]  level;
        logic [2:0]  div_cnt;
        logic [2:0]  irq;
        logic        pout;
        logic [15:0] rdata;
    } tcap_state_t;

    tcap_state_t s_q;
    tcap_state_t s_d;

    // ==========================================================
    // Edge qualifier shared by all three channels
    function automatic logic edge_hit(input logic [1:0] sel,
                                      input logic old_l,
                                      input logic new_l);
        logic rise;
        logic fall;
        rise = !old_l && new_l;
        fall = old_l && !new_l;
        case (sel)
            tcap_pkg::EDGE_FALL: edge_hit = fall;
            tcap_pkg::EDGE_RISE: edge_hit = rise;
            tcap_pkg::EDGE_BOTH: edge_hit = rise || fall;
            default:             edge_hit = 1'b0;
        endcase
    endfunction

    logic       run;
    logic       tick;
    logic [1:0] psel;
    logic [2:0] hit;
    logic [2:0] trig;
    logic [2:0] div_mask;

    // ==========================================================
    // Next state
    always_comb begin
        s_d = s_q;
        // R07: run control
        run  = s_q.mode[tcap_pkg::MODE_RUN_BIT];
        psel = s_q.prs[tcap_pkg::PRS_SEL_LSB +: 2];
        // R14: tick when the selected prescaler bits all wrap
        tick = run && (s_q.pre[3'(psel) + 3'(tcap_pkg::PRS_BASE_LOG2 - 1)
                       -: 1] == 1'b1)
               && ((s_q.pre & ((6'h01 << (3'(psel) + 3'(
                   tcap_pkg::PRS_BASE_LOG2))) - 6'h01))
                   == ((6'h01 << (3'(psel) + 3'(
                   tcap_pkg::PRS_BASE_LOG2))) - 6'h01));
        s_d.pre = run ? s_q.pre + 6'h01 : 6'h00;
        // R08: gated prescaler output, square at the count rate
        s_d.pout = s_q.mode[tcap_pkg::MODE_OUT_EN_BIT] && run
                   && s_q.pre[3'(psel) + 3'(tcap_pkg::PRS_BASE_LOG2 - 1)];
        // R01: count on tick; R19: free wrap; R02: holds when stopped
        if (tick) begin
            s_d.count = s_q.count + 16'h0001;
        end
        // Pin synchroniser, first stage read only by second
        s_d.sync1 = {CAPTURE_INPUT_TWO, CAPTURE_INPUT_ONE,
                     CAPTURE_INPUT_ZERO};
        s_d.sync2 = s_q.sync1;
        // R18: sample at count clock, two equal samples accepted
        hit = 3'h0;
        if (tick) begin
            s_d.samp_a = s_q.sync2;
            for (int i = 0; i < 3; i++) begin
                if (s_q.sync2[i] == s_q.samp_a[i]) begin
                    s_d.level[i] = s_q.sync2[i];
                    // R13: per-channel valid edge
                    hit[i] = edge_hit(
                        s_q.prs[tcap_pkg::EDGE0_LSB + 2 * i +: 2],
                        s_q.level[i], s_q.sync2[i]);
                end
            end
        end
        // R11: channel two divider, one of 1, 2, 4, 8 edges
        div_mask = 3'((4'h1 << s_q.div[tcap_pkg::DIV_SEL_LSB +: 2])
                      - 4'h1);
        trig = hit;
        trig[2] = 1'b0;
        if (hit[2]) begin
            if ((s_q.div_cnt & div_mask) == div_mask) begin
                s_d.div_cnt = 3'h0;
                trig[2] = 1'b1;
            end else begin
                s_d.div_cnt = s_q.div_cnt + 3'h1;
            end
        end
        if (!run) begin
            s_d.div_cnt = 3'h0;
        end
        // R03 R04 R05: capture and one-cycle interrupt pulses
        // R17: copy current counter
        s_d.irq = trig;
        if (trig[0]) begin
            s_d.cap0 = s_q.count;
        end
        if (trig[1]) begin
            s_d.cap1 = s_q.count;
        end
        if (trig[2]) begin
            s_d.cap2 = s_q.count;
        end
        // R16: byte writes to mode, prescale and divider, bit writes to mode only
        if (WR_BYTE) begin
            if (ADDR == tcap_pkg::ADDR_MODE) begin
                s_d.mode = WDATA;
            end else if (ADDR == tcap_pkg::ADDR_PRESCALE) begin
                s_d.prs = WDATA;
            end else if (ADDR == tcap_pkg::ADDR_DIVIDER) begin
                s_d.div = WDATA;
            end
        end else if (WR_BIT && ADDR == tcap_pkg::ADDR_MODE) begin
            s_d.mode[BIT_SEL] = BIT_VAL;
        end
        // R06: capture values read whole as 16 bits
        if (RD) begin
            if (ADDR == tcap_pkg::ADDR_MODE) begin
                s_d.rdata = {8'h00, s_q.mode};
            end else if (ADDR == tcap_pkg::ADDR_PRESCALE) begin
                s_d.rdata = {8'h00, s_q.prs};
            end else if (ADDR == tcap_pkg::ADDR_DIVIDER) begin
                s_d.rdata = {8'h00, s_q.div};
            end else if (ADDR == tcap_pkg::ADDR_COUNT) begin
                s_d.rdata = s_q.count;
            end else if (ADDR == tcap_pkg::ADDR_CAP0) begin
                s_d.rdata = s_q.cap0;
            end else if (ADDR == tcap_pkg::ADDR_CAP1) begin
                s_d.rdata = s_q.cap1;
            end else if (ADDR == tcap_pkg::ADDR_CAP2) begin
                s_d.rdata = s_q.cap2;
            end else begin
                s_d.rdata = 16'h0000;
            end
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge REF_CLK) begin
        s_q <= s_d;
        if (SRST) begin
            // R16: mode clears; R01: counter clears
            s_q.mode    <= tcap_pkg::MODE_RST;
            s_q.prs     <= tcap_pkg::PRESCALE_RST;
            s_q.div     <= tcap_pkg::DIVIDER_RST;
            s_q.count   <= tcap_pkg::COUNT_RST;
            s_q.pre     <= 6'h00;
            s_q.sync1   <= 3'h0;
            s_q.sync2   <= 3'h0;
            s_q.samp_a  <= 3'h0;
            s_q.level   <= 3'h0;
            s_q.div_cnt <= 3'h0;
            s_q.irq     <= 3'h0;
            s_q.pout    <= 1'b0;
            s_q.rdata   <= 16'h0000;
        end
    end

    // ==========================================================
    // Outputs
    assign RDATA            = s_q.rdata;
    assign CAPTURE_IRQ_ZERO = s_q.irq[0];
    assign CAPTURE_IRQ_ONE  = s_q.irq[1];
    assign CAPTURE_IRQ_TWO  = s_q.irq[2];
    assign PRESCALER_OUT    = s_q.pout;
endmodule

//--- bench/tcap_pins.sv
// Purpose: far-side model driving the three capture pins
// Assumes: bench sets requested levels just after a clock edge
// Notes:   pins move only on rising edges, never glitch mid-cycle
`timescale 1ns/1ps
module tcap_pins (
    input  wire logic       clk,
    input  wire logic [2:0] lvl,
    output logic      [2:0] pin
);
    initial pin = 3'h0;
    always @(posedge clk) begin
        pin <= lvl;
    end
endmodule

//--- bench/tcap_timer_sva.sv
// Purpose: port-level checks of the capture timer
// Assumes: mode shadow follows the register port writes
// Notes:   counter value is not visible here
`timescale 1ns/1ps
module tcap_sva (
    input wire logic        REF_CLK,
    input wire logic        SRST,
    input wire logic [15:0] ADDR,
    input wire logic        WR_BYTE,
    input wire logic        WR_BIT,
    input wire logic [2:0]  BIT_SEL,
    input wire logic        BIT_VAL,
    input wire logic [7:0]  WDATA,
    input wire logic        RD,
    input wire logic [15:0] RDATA,
    input wire logic        CAPTURE_IRQ_ZERO,
    input wire logic        CAPTURE_IRQ_ONE,
    input wire logic        CAPTURE_IRQ_TWO,
    input wire logic        PRESCALER_OUT
);
    logic [7:0] mode_q;
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            mode_q <= tcap_pkg::MODE_RST;
        end else if (WR_BYTE && ADDR == tcap_pkg::ADDR_MODE) begin
            mode_q <= WDATA;
        end else if (WR_BIT && ADDR == tcap_pkg::ADDR_MODE) begin
            mode_q[BIT_SEL] <= BIT_VAL;
        end
    end
    default clocking dck @(posedge REF_CLK); endclocking
    default disable iff (SRST);
    // Ticks come at most every 8 cycles, so pulses are spaced
    irq_zero_gap_a: assert property (CAPTURE_IRQ_ZERO |=>
        (!CAPTURE_IRQ_ZERO) [*7]) else $error("irq zero too close");
    irq_one_gap_a: assert property (CAPTURE_IRQ_ONE |=>
        (!CAPTURE_IRQ_ONE) [*7]) else $error("irq one too close");
    irq_two_gap_a: assert property (CAPTURE_IRQ_TWO |=>
        (!CAPTURE_IRQ_TWO) [*7]) else $error("irq two too close");
    reset_clear_a: assert property (disable iff (1'b0) SRST |=>
        RDATA == 16'h0000 && !PRESCALER_OUT && !CAPTURE_IRQ_ZERO)
        else $error("outputs not cleared by reset");
    stopped_quiet_a: assert property ((!mode_q[2]) [*4] |->
        !(CAPTURE_IRQ_ZERO || CAPTURE_IRQ_ONE || CAPTURE_IRQ_TWO))
        else $error("capture while stopped");
    out_gate_a: assert property ((!(mode_q[0] && mode_q[2])) [*3]
        |-> !PRESCALER_OUT) else $error("prescaler output not gated");
    mode_read_a: assert property (RD && ADDR == tcap_pkg::ADDR_MODE
        |=> RDATA == {8'h00, $past(mode_q)}) else $error("mode readback");
    byte_upper_a: assert property (RD
        && (ADDR == tcap_pkg::ADDR_PRESCALE || ADDR == tcap_pkg::ADDR_DIVIDER)
        |=> RDATA[15:8] == 8'h00) else $error("byte register upper half set");
    cover property (CAPTURE_IRQ_ZERO);
    cover property (CAPTURE_IRQ_TWO);
    cover property (mode_q[2] && CAPTURE_IRQ_ONE);
    cover property (PRESCALER_OUT);
endmodule
bind tcap_timer tcap_sva u_sva (.REF_CLK(REF_CLK), .SRST(SRST), .ADDR(ADDR),
    .WR_BYTE(WR_BYTE), .WR_BIT(WR_BIT), .BIT_SEL(BIT_SEL), .BIT_VAL(BIT_VAL),
    .WDATA(WDATA), .RD(RD), .RDATA(RDATA), .CAPTURE_IRQ_ZERO(CAPTURE_IRQ_ZERO),
    .CAPTURE_IRQ_ONE(CAPTURE_IRQ_ONE), .CAPTURE_IRQ_TWO(CAPTURE_IRQ_TWO),
    .PRESCALER_OUT(PRESCALER_OUT));

//--- bench/tcap_timer_tb.sv
// Purpose: register and capture tests of the capture timer
// Assumes: pins held 40 cycles, five count periods at code 0
// Notes:   counter only read while running, its value is loose else
`timescale 1ns/1ps
module tcap_timer_tb;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic        wb = 1'b0;
    logic        wt = 1'b0;
    logic        bv = 1'b0;
    logic [2:0]  bs = 3'h2;
    logic        pout;
    int          hi;
    logic [7:0]  wd = 8'h00;
    logic        rs = 1'b0;
    logic [2:0]  lvl = 3'h0;
    logic [2:0]  pin;
    logic [2:0]  irq;
    logic [15:0] rdata;
    logic [15:0] v;
    logic [15:0] w;
    int          n_fail = 0;
    int          compares = 0;
    int          cnt [3] = '{0, 0, 0};
    localparam logic [15:0] EXP_E [4] = '{16'h1, 16'h1, 16'h0, 16'h2};
    always #50 clk = ~clk;
    // Counted at negedge, away from the bench's own edge
    always @(negedge clk) begin
        for (int c = 0; c < 3; c++) if (irq[c] === 1'b1) cnt[c]++;
    end
    tcap_pins u_pins (.clk(clk), .lvl(lvl), .pin(pin));
    tcap_timer dut (.REF_CLK(clk), .SRST(srst), .ADDR(addr), .WR_BYTE(wb),
        .WR_BIT(wt), .BIT_SEL(bs), .BIT_VAL(bv), .WDATA(wd), .RD(rs),
        .CAPTURE_INPUT_ZERO(pin[0]), .CAPTURE_INPUT_ONE(pin[1]),
        .CAPTURE_INPUT_TWO(pin[2]), .RDATA(rdata), .CAPTURE_IRQ_ZERO(irq[0]),
        .CAPTURE_IRQ_ONE(irq[1]), .CAPTURE_IRQ_TWO(irq[2]),
        .PRESCALER_OUT(pout));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wb <= 1'b1;
        @(posedge clk);
        wb <= 1'b0;
    endtask
    task automatic bw(input logic [2:0] n, input logic b);
        @(posedge clk);
        addr <= tcap_pkg::ADDR_MODE;
        bs <= n;
        bv <= b;
        wt <= 1'b1;
        @(posedge clk);
        wt <= 1'b0;
    endtask
    task automatic run(input logic b);
        bw(3'(tcap_pkg::MODE_RUN_BIT), b);
    endtask
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rs <= 1'b1;
        @(posedge clk);
        rs <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    task automatic pins(input logic [2:0] l);
        lvl <= l;
        repeat (40) @(posedge clk);
    endtask
    task automatic tally_and_finish();
        if (n_fail == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        n_fail++;
        tally_and_finish();
    end
    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            rd(tcap_pkg::ADDR_MODE + 16'(i), v);
            chk(v, 16'h0000);
        end
        rd(16'h0000, v);
        chk(v, 16'h0000);
        run(1'b1);
        rd(tcap_pkg::ADDR_MODE, v);
        chk(v, 16'h0004);
        run(1'b0);
        pins(3'h7);
        pins(3'h0);
        chk(16'(cnt[0] + cnt[1] + cnt[2]), 16'h0000);
        // stopped, then four ticks per span
        for (int s = 0; s < 4; s++) begin
            wr(tcap_pkg::ADDR_PRESCALE, 8'(s));
            run(1'b1);
            rd(tcap_pkg::ADDR_COUNT, v);
            repeat ((32 << s) - 2) @(posedge clk);
            rd(tcap_pkg::ADDR_COUNT, w);
            chk(w - v, 16'h0004);
            run(1'b0);
        end
        for (int e = 0; e < 4; e++) begin
            wr(tcap_pkg::ADDR_PRESCALE, {2'(e), 2'(e), 2'(e), 2'h0});
            cnt = '{0, 0, 0};
            run(1'b1);
            pins(3'h7);
            pins(3'h0);
            run(1'b0);
            for (int c = 0; c < 3; c++) chk(16'(cnt[c]), EXP_E[e]);
        end
        wr(tcap_pkg::ADDR_PRESCALE, 8'h54);
        cnt = '{0, 0, 0};
        run(1'b1);
        lvl <= 3'h1;
        @(posedge clk);
        lvl <= 3'h0;
        repeat (40) @(posedge clk);
        chk(16'(cnt[0]), 16'h0000);
        lvl <= 3'h7;
        for (int t = 0; t < 60 && irq[0] !== 1'b1; t++) @(negedge clk);
        chk(16'(irq[0]), 16'h0001);
        rd(tcap_pkg::ADDR_CAP0, v);
        rd(tcap_pkg::ADDR_COUNT, w);
        chk(w, v + 16'h0001);
        rd(tcap_pkg::ADDR_CAP1, w);
        chk(w, v);
        rd(tcap_pkg::ADDR_CAP2, w);
        chk(w, v);
        pins(3'h0);
        run(1'b0);
        wr(tcap_pkg::ADDR_PRESCALE, 8'hC0);
        for (int d = 0; d < 4; d++) begin
            wr(tcap_pkg::ADDR_DIVIDER, 8'(d));
            cnt = '{0, 0, 0};
            run(1'b1);
            repeat (4) begin
                pins(3'h4);
                pins(3'h0);
            end
            run(1'b0);
            chk(16'(cnt[2]), 16'(8 >> d));
        end
        bw(3'(tcap_pkg::MODE_OUT_EN_BIT), 1'b1);
        run(1'b1);
        rd(tcap_pkg::ADDR_MODE, v);
        chk(v, 16'h0005);
        hi = 0;
        repeat (16) begin
            @(negedge clk);
            if (pout === 1'b1) hi++;
        end
        chk(16'(hi), 16'h0008);
        bw(3'(tcap_pkg::MODE_OUT_EN_BIT), 1'b0);
        repeat (2) @(posedge clk);
        hi = 0;
        repeat (16) begin
            @(negedge clk);
            if (pout === 1'b1) hi++;
        end
        chk(16'(hi), 16'h0000);
        run(1'b0);
        tally_and_finish();
    end
endmodule
